// ### agcc_gain_and_carrier_sense_cfg.sv
// agcc_gain_and_carrier_sense_cfg: two AGC configuration registers and
// the decoded settings handed to the gain and carrier sense logic.
// assumes the serial host port gives byte-wide write/read strobes.
// Overview of operation
// (R1) digital gain ceiling bars top N steps
// (R2) front-end ceiling code caps combined gain
// (R3) target code selects averaged amplitude target
// (R4) priority set: reduce first stage first
// (R5) priority clear: second stage to minimum first
// (R6) relative sense rise 6/10/14 dB, 0 off
// (R7) absolute threshold signed dB offset from target
// (R8) absolute code 1000 disables absolute sensing
// (R9) bit 7 of second register reads zero
`timescale 1ns/1ps
module agcc_gain_and_carrier_sense_cfg
  import agcc_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] wdata_in,
  output logic [DATA_W-1:0] rdata_out,
  output logic rvalid_out,
  output agcc_cfg_t cfg_out
);
  logic rst_meta;
  logic rst_sync;
  logic [7:0] gain_limits;
  logic [7:0] prio_sense;
  logic [7:0] next_rdata;
  agcc_cfg_t next_cfg;

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  agcc_reg8 #(
    .RESET_VALUE(RST_GAIN_LIMITS),
    .WRITE_MASK(8'hff)
  ) u_gain_limits (
    .clk_in(mclk_in),
    .rst_n_in(rst_sync),
    .we_in(wr_en_in && addr_in == OFS_GAIN_LIMITS),
    .wdata_in(wdata_in),
    .q_out(gain_limits)
  );

  // unused top bit is masked on write so it never stores
  agcc_reg8 #(
    .RESET_VALUE(RST_PRIO_SENSE),
    .WRITE_MASK(WRITE_MASK_PRIO)
  ) u_prio_sense (
    .clk_in(mclk_in),
    .rst_n_in(rst_sync),
    .we_in(wr_en_in && addr_in == OFS_PRIO_SENSE), // see (R9)
    .wdata_in(wdata_in),
    .q_out(prio_sense)
  );

  always_comb begin
    case (addr_in)
      OFS_GAIN_LIMITS: next_rdata = gain_limits;
      OFS_PRIO_SENSE: next_rdata = prio_sense & WRITE_MASK_PRIO; // see (R9)
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge mclk_in or negedge rst_sync) begin
    if (!rst_sync) begin
      rdata_out <= 8'h00;
      rvalid_out <= 1'b0;
    end else begin
      rvalid_out <= rd_en_in;
      if (rd_en_in) begin
        rdata_out <= next_rdata;
      end
    end
  end

  // one decode serves both the live settings and the reset image
  function automatic agcc_cfg_t decode_cfg(input logic [7:0] gain,
                                           input logic [7:0] prio);
    agcc_cfg_t cfg;
    logic [7:0] target;
    target = TARGET_DB[gain[TARGET_HI:TARGET_LO]];
    cfg.digital_steps_barred = gain[DIG_CEIL_HI:DIG_CEIL_LO]; // see (R1)
    cfg.front_end_cut_tenths =
      FE_CUT_TENTHS[gain[FE_CEIL_HI:FE_CEIL_LO]]; // see (R2)
    cfg.amplitude_target_db = target; // see (R3)
    // see (R4) (R5)
    cfg.gain_reduction_order = prio[PRIO_BIT] ?
      AGCC_FRONT_FIRST : AGCC_SECOND_FIRST;
    cfg.relative_sense_en =
      prio[REL_HI:REL_LO] != 2'b00; // see (R6)
    cfg.relative_rise_db = REL_STEP_DB[prio[REL_HI:REL_LO]];
    cfg.absolute_sense_en =
      prio[ABS_HI:ABS_LO] != ABS_DISABLE_CODE; // see (R8)
    // still computed when disabled; users must gate on the enable
    cfg.absolute_threshold_db = $signed(target) + $signed({{4{
      prio[ABS_HI]}}, prio[ABS_HI:ABS_LO]}); // see (R7)
    return cfg;
  endfunction

  localparam agcc_cfg_t CFG_RESET =
    decode_cfg(RST_GAIN_LIMITS, RST_PRIO_SENSE);

  always_comb begin
    next_cfg = decode_cfg(gain_limits, prio_sense);
  end

  // registered so downstream sees glitch-free settings
  always_ff @(posedge mclk_in or negedge rst_sync) begin
    if (!rst_sync) begin
      cfg_out <= CFG_RESET;
    end else begin
      cfg_out <= next_cfg;
    end
  end

  a_unused_reads_zero: assert property (@(posedge mclk_in) // see (R9)
    disable iff (!rst_sync)
    rd_en_in && addr_in == OFS_PRIO_SENSE |=> !rdata_out[UNUSED_BIT])
    else $error("unused bit read nonzero");
  a_unused_write_ignored: assert property (@(posedge mclk_in) // see (R9)
    disable iff (!rst_sync)
    wr_en_in && addr_in == OFS_PRIO_SENSE
      |=> !prio_sense[UNUSED_BIT])
    else $error("unused bit stored");
  a_gain_write_lands: assert property (@(posedge mclk_in) // see (R1)
    disable iff (!rst_sync)
    wr_en_in && addr_in == OFS_GAIN_LIMITS
      |=> gain_limits == $past(wdata_in))
    else $error("gain limits write lost");
  a_prio_write_lands: assert property (@(posedge mclk_in) // see (R4)
    disable iff (!rst_sync)
    wr_en_in && addr_in == OFS_PRIO_SENSE
      |=> prio_sense[PRIO_BIT:ABS_LO] == $past(wdata_in[PRIO_BIT:ABS_LO]))
    else $error("priority and sense write lost");
  a_abs_disable_code: assert property (@(posedge mclk_in) // see (R8)
    disable iff (!rst_sync)
    prio_sense[ABS_HI:ABS_LO] == ABS_DISABLE_CODE
      |=> !cfg_out.absolute_sense_en)
    else $error("absolute sense not disabled");
  a_abs_enable: assert property (@(posedge mclk_in) // see (R8)
    disable iff (!rst_sync)
    prio_sense[ABS_HI:ABS_LO] != ABS_DISABLE_CODE
      |=> cfg_out.absolute_sense_en)
    else $error("absolute sense not enabled");
  a_rel_disable: assert property (@(posedge mclk_in) // see (R6)
    disable iff (!rst_sync)
    $past(prio_sense[REL_HI:REL_LO]) == 2'b00 |-> !cfg_out.relative_sense_en)
    else $error("relative sense not disabled");
  a_rel_enable: assert property (@(posedge mclk_in) // see (R6)
    disable iff (!rst_sync)
    prio_sense[REL_HI:REL_LO] != 2'b00
      |=> cfg_out.relative_sense_en)
    else $error("relative sense not enabled");
  a_rel_six: assert property (@(posedge mclk_in) // see (R6)
    disable iff (!rst_sync)
    prio_sense[REL_HI:REL_LO] == 2'b01
      |=> cfg_out.relative_rise_db == 8'h06)
    else $error("relative rise six wrong");
  a_rel_ten: assert property (@(posedge mclk_in) // see (R6)
    disable iff (!rst_sync)
    prio_sense[REL_HI:REL_LO] == 2'b10
      |=> cfg_out.relative_rise_db == 8'h0a)
    else $error("relative rise ten wrong");
  a_rel_fourteen: assert property (@(posedge mclk_in) // see (R6)
    disable iff (!rst_sync)
    prio_sense[REL_HI:REL_LO] == 2'b11 |=> cfg_out.relative_rise_db == 8'h0e)
    else $error("relative rise wrong");
  a_prio_front: assert property (@(posedge mclk_in) // see (R4)
    disable iff (!rst_sync)
    prio_sense[PRIO_BIT] |=> cfg_out.gain_reduction_order == AGCC_FRONT_FIRST)
    else $error("order not front first");
  a_prio_second: assert property (@(posedge mclk_in) // see (R5)
    disable iff (!rst_sync)
    !prio_sense[PRIO_BIT]
      |=> cfg_out.gain_reduction_order == AGCC_SECOND_FIRST)
    else $error("order not second first");
  a_target_top: assert property (@(posedge mclk_in) // see (R3)
    disable iff (!rst_sync)
    gain_limits[TARGET_HI:TARGET_LO] == 3'h7
      |=> cfg_out.amplitude_target_db == 8'h2a)
    else $error("target code 7 wrong");
  a_target_base: assert property (@(posedge mclk_in) // see (R3)
    disable iff (!rst_sync)
    gain_limits[TARGET_HI:TARGET_LO] == 3'h0
      |=> cfg_out.amplitude_target_db == 8'h18)
    else $error("target code 0 wrong");
  a_fe_cut_top: assert property (@(posedge mclk_in) // see (R2)
    disable iff (!rst_sync)
    gain_limits[FE_CEIL_HI:FE_CEIL_LO] == 3'h7
      |=> cfg_out.front_end_cut_tenths == 8'hab)
    else $error("front-end cap wrong");
  a_fe_cut_none: assert property (@(posedge mclk_in) // see (R2)
    disable iff (!rst_sync)
    gain_limits[FE_CEIL_HI:FE_CEIL_LO] == 3'h0
      |=> cfg_out.front_end_cut_tenths == 8'h00)
    else $error("front-end full gain wrong");
  a_dig_ceiling: assert property (@(posedge mclk_in) // see (R1)
    disable iff (!rst_sync)
    wr_en_in && addr_in == OFS_GAIN_LIMITS ##1 1'b1
      |=> cfg_out.digital_steps_barred ==
        $past(wdata_in[DIG_CEIL_HI:DIG_CEIL_LO], 2))
    else $error("digital ceiling not written");
  a_dig_ceiling_zero: assert property (@(posedge mclk_in) // see (R1)
    disable iff (!rst_sync)
    gain_limits[DIG_CEIL_HI:DIG_CEIL_LO] == 2'h0
      |=> cfg_out.digital_steps_barred == 2'h0)
    else $error("digital steps barred at code 0");
  a_abs_offset: assert property (@(posedge mclk_in) // see (R7)
    disable iff (!rst_sync)
    gain_limits[TARGET_HI:TARGET_LO] == 3'h0
      && prio_sense[ABS_HI:ABS_LO] == 4'h9
      |=> cfg_out.absolute_threshold_db == 8'sh11)
    else $error("absolute offset wrong");
  a_abs_plus_seven: assert property (@(posedge mclk_in) // see (R7)
    disable iff (!rst_sync)
    gain_limits[TARGET_HI:TARGET_LO] == 3'h0
      && prio_sense[ABS_HI:ABS_LO] == 4'h7
      |=> cfg_out.absolute_threshold_db == 8'sh1f)
    else $error("absolute offset plus seven wrong");
  a_abs_at_target: assert property (@(posedge mclk_in) // see (R7)
    disable iff (!rst_sync)
    gain_limits[TARGET_HI:TARGET_LO] == 3'h3
      && prio_sense[ABS_HI:ABS_LO] == 4'h0
      |=> cfg_out.absolute_threshold_db == 8'sh21)
    else $error("absolute offset zero wrong");
endmodule // agcc_gain_and_carrier_sense_cfg

// ### agcc_pkg.sv
// agcc_pkg: register map, field layout, reset values and decode tables
// for the gain control and carrier sense configuration bank.
// assumes an 8-bit register port from the serial host interface.
package agcc_pkg;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam logic [5:0] OFS_GAIN_LIMITS = 6'h1b;
  localparam logic [5:0] OFS_PRIO_SENSE = 6'h1c;

  localparam int DIG_CEIL_HI = 7;
  localparam int DIG_CEIL_LO = 6;
  localparam int FE_CEIL_HI = 5;
  localparam int FE_CEIL_LO = 3;
  localparam int TARGET_HI = 2;
  localparam int TARGET_LO = 0;
  localparam int PRIO_BIT = 6;
  localparam int UNUSED_BIT = 7;
  localparam int REL_HI = 5;
  localparam int REL_LO = 4;
  localparam int ABS_HI = 3;
  localparam int ABS_LO = 0;

  localparam logic [7:0] RST_GAIN_LIMITS = 8'h03;
  localparam logic [7:0] RST_PRIO_SENSE = 8'h40;
  localparam logic [7:0] WRITE_MASK_PRIO = 8'h7f;
  localparam logic [3:0] ABS_DISABLE_CODE = 4'h8;

  // gains in tenths of a dB below maximum, per ceiling code
  localparam logic [7:0] FE_CUT_TENTHS [8] = '{
    8'h00, 8'h1a, 8'h3d, 8'h4a, 8'h5c, 8'h73, 8'h92, 8'hab};
  // targets in dB per code
  localparam logic [7:0] TARGET_DB [8] = '{
    8'h18, 8'h1b, 8'h1e, 8'h21, 8'h24, 8'h26, 8'h28, 8'h2a};
  localparam logic [7:0] REL_STEP_DB [4] = '{
    8'h00, 8'h06, 8'h0a, 8'h0e};

  typedef enum logic [1:0] {
    AGCC_FRONT_FIRST = 2'b01,
    AGCC_SECOND_FIRST = 2'b10
  } agcc_order_t;

  typedef struct packed {
    logic [1:0] digital_steps_barred;
    logic [7:0] front_end_cut_tenths;
    logic [7:0] amplitude_target_db;
    agcc_order_t gain_reduction_order;
    logic relative_sense_en;
    logic [7:0] relative_rise_db;
    logic absolute_sense_en;
    logic signed [7:0] absolute_threshold_db;
  } agcc_cfg_t;
endpackage

// ### agcc_reg8.sv
// agcc_reg8: one 8-bit configuration register with write mask.
// assumes a synchronised active-low reset on the same clock.
`timescale 1ns/1ps
module agcc_reg8
  import agcc_pkg::*;
#(
  parameter logic [7:0] RESET_VALUE = 8'h00,
  parameter logic [7:0] WRITE_MASK = 8'hff
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic we_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] q_out
);
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q_out <= RESET_VALUE;
    end else if (we_in) begin
      // masked bits hold their reset value forever
      q_out <= (wdata_in & WRITE_MASK) | (RESET_VALUE & ~WRITE_MASK);
    end
  end
endmodule // agcc_reg8

// ### test_agcc_gain_and_carrier_sense_cfg.sv
// test_agcc_gain_and_carrier_sense_cfg: self-checking bench for the
// gain control and carrier sense configuration bank.
// assumes agcc_pkg is compiled first; the bench drives every port itself.
`timescale 1ns/1ps
module test_agcc_gain_and_carrier_sense_cfg
  import agcc_pkg::*;
;
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic wr_en_in = 1'b0;
  logic rd_en_in = 1'b0;
  logic [ADDR_W-1:0] addr_in = '0;
  logic [DATA_W-1:0] wdata_in = '0;
  logic [DATA_W-1:0] rdata_out;
  logic rvalid_out;
  agcc_cfg_t cfg_out;
  int num_errors = 0;
  int samples_checked = 0;
  logic [7:0] gain_reg = 8'h03;
  logic [7:0] prio_reg = 8'h40;

  always #50 mclk_in = ~mclk_in;

  agcc_gain_and_carrier_sense_cfg i_agcc_gain_and_carrier_sense_cfg (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .wr_en_in(wr_en_in),
    .rd_en_in(rd_en_in),
    .addr_in(addr_in),
    .wdata_in(wdata_in),
    .rdata_out(rdata_out),
    .rvalid_out(rvalid_out),
    .cfg_out(cfg_out)
  );

  task automatic summarize();
    $display("checked %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp,
                     input string what);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  function automatic agcc_cfg_t exp_cfg(input logic [7:0] g,
                                        input logic [7:0] p);
    logic [7:0] cut [8] = '{8'h00, 8'h1a, 8'h3d, 8'h4a, 8'h5c, 8'h73,
                            8'h92, 8'hab};
    logic [7:0] tgt [8] = '{8'h18, 8'h1b, 8'h1e, 8'h21, 8'h24, 8'h26,
                            8'h28, 8'h2a};
    logic [7:0] rel [4] = '{8'h00, 8'h06, 8'h0a, 8'h0e};
    agcc_cfg_t e;
    e.digital_steps_barred = g[7:6];
    e.front_end_cut_tenths = cut[g[5:3]];
    e.amplitude_target_db = tgt[g[2:0]];
    e.gain_reduction_order = p[6] ? AGCC_FRONT_FIRST : AGCC_SECOND_FIRST;
    e.relative_sense_en = (p[5:4] != 2'b00);
    e.relative_rise_db = rel[p[5:4]];
    e.absolute_sense_en = (p[3:0] != 4'h8);
    e.absolute_threshold_db = tgt[g[2:0]] + {{4{p[3]}}, p[3:0]};
    return e;
  endfunction

  task automatic chk_cfg();
    agcc_cfg_t e;
    e = exp_cfg(gain_reg, prio_reg);
    // threshold value means nothing while absolute sensing is off
    if (!e.absolute_sense_en) begin
      e.absolute_threshold_db = cfg_out.absolute_threshold_db;
    end
    chk(cfg_out, e, "decoded settings");
  endtask

  // returns after the decoded settings have had their extra cycle
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge mclk_in);
    wr_en_in = 1'b1;
    addr_in = a;
    wdata_in = d;
    @(negedge mclk_in);
    wr_en_in = 1'b0;
    @(negedge mclk_in);
  endtask

  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    @(negedge mclk_in);
    rd_en_in = 1'b1;
    addr_in = a;
    @(negedge mclk_in);
    rd_en_in = 1'b0;
    chk(rvalid_out, 1'b1, "read valid");
    chk(rdata_out, exp, "read data");
  endtask

  task automatic t_reset();
    rd(OFS_GAIN_LIMITS, 8'h03);
    rd(OFS_PRIO_SENSE, 8'h40);
    chk_cfg();
    $display("test reset done");
  endtask

  task automatic t_gain();
    for (int i = 0; i < 8; i++) begin
      gain_reg = {i[1:0], i[2:0], 3'(7 - i)};
      wr(OFS_GAIN_LIMITS, gain_reg);
      chk_cfg();
      rd(OFS_GAIN_LIMITS, gain_reg);
    end
    $display("test gain limits done");
  endtask

  // bit 7 is always written high to prove it never sticks
  task automatic t_prio();
    for (int i = 0; i < 16; i++) begin
      prio_reg = {1'b0, i[0], i[2:1], i[3:0]};
      wr(OFS_PRIO_SENSE, prio_reg | 8'h80);
      chk_cfg();
      rd(OFS_PRIO_SENSE, prio_reg);
    end
    $display("test priority and sense done");
  endtask

  task automatic t_unmapped();
    wr(6'h1d, 8'hff);
    rd(6'h1d, 8'h00);
    rd(OFS_GAIN_LIMITS, gain_reg);
    chk_cfg();
    $display("test unmapped done");
  endtask

  // read and write in one cycle: the read sees the old contents
  task automatic t_same_cycle();
    @(negedge mclk_in);
    wr_en_in = 1'b1;
    rd_en_in = 1'b1;
    addr_in = OFS_GAIN_LIMITS;
    wdata_in = 8'h5a;
    @(negedge mclk_in);
    wr_en_in = 1'b0;
    rd_en_in = 1'b0;
    chk(rvalid_out, 1'b1, "valid beside write");
    chk(rdata_out, gain_reg, "read beside write");
    gain_reg = 8'h5a;
    @(negedge mclk_in);
    chk_cfg();
    rd(OFS_GAIN_LIMITS, gain_reg);
    $display("test same cycle done");
  endtask

  // reset in mid-run must bring back every default at once
  task automatic t_mid_reset();
    wr(OFS_GAIN_LIMITS, 8'hff);
    wr(OFS_PRIO_SENSE, 8'h3f);
    gain_reg = 8'h03;
    prio_reg = 8'h40;
    @(negedge mclk_in);
    rst_n_in = 1'b0;
    repeat (2) @(negedge mclk_in);
    chk(rvalid_out, 1'b0, "valid held in reset");
    chk(rdata_out, 8'h00, "data held in reset");
    chk_cfg();
    rst_n_in = 1'b1;
    repeat (4) @(negedge mclk_in);
    t_reset();
    $display("test mid-run reset done");
  endtask

  initial begin
    repeat (6) @(negedge mclk_in);
    rst_n_in = 1'b1;
    repeat (4) @(negedge mclk_in);
    t_reset();
    t_gain();
    t_prio();
    t_unmapped();
    t_same_cycle();
    t_mid_reset();
    summarize();
  end

  // run needs about 163 cycles; about eighteen times that is a hang
  initial begin
    repeat (3000) @(posedge mclk_in);
    num_errors++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    summarize();
  end
endmodule // test_agcc_gain_and_carrier_sense_cfg
